// file: period_match_timer_8bit.sv
// 8-bit period match timer with prescaler, postscaler and interrupt.
// Assumes an AXI4-Lite master on clk_i and an active-high async reset.
`timescale 1ns/1ns

// Notes on behaviour
// - Count up, wrap to zero after period match
// - Period register resets to all ones, read/write
// - Core clock over four, prescale 1/4/16
// - Match postscaler ratio is code plus one
// - Postscaler event sets match flag bit one
// - Counter/control writes and reset clear scalers
// - Control write leaves counter value alone
// - Counter clears on reset, always read/write
// - Clearing run enable bit two halts counting
// - Prescaled match pulse goes to serial port
// - Counter and match feed PWM time base
module period_match_timer_8bit (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [31:0]                 s_axi_wdata_i,
   input  wire logic [3:0]                  s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic [1:0]                       s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic [31:0]                      s_axi_rdata_o,
   output logic [1:0]                       s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   output logic [7:0]                       counter_value_o,
   output logic [7:0]                       period_value_o,
   output logic                             match_pulse_o,
   output logic                             irq_o
);
   import timer_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-3:0] idx;
      idx = addr[ADDR_W-1:2];
      case (idx)
         {2'h0, IDX_INT_MASTER}: decode = SEL_INT_MASTER;
         {2'h0, IDX_FLAG}:       decode = SEL_FLAG;
         {2'h0, IDX_COUNTER}:    decode = SEL_COUNTER;
         {2'h0, IDX_CONTROL}:    decode = SEL_CONTROL;
         {2'h0, IDX_ENABLE}:     decode = SEL_ENABLE;
         {2'h0, IDX_PERIOD}:     decode = SEL_PERIOD;
         default:                decode = SEL_NONE;
      endcase
   endfunction : decode

   ////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0]              int_master;
   logic [7:0]              enable_reg;
   logic                    match_flag;
   logic [7:0]              period_counter;
   logic [6:0]              timer_scaling_control;
   logic [7:0]              period_compare_value;

   logic                    aw_held;
   logic                    w_held;
   logic [ADDR_W-1:0]       aw_addr;
   logic [7:0]              w_byte;
   logic                    w_lane0;
   logic                    do_write;
   reg_sel_t                wsel;
   logic                    wr_go;
   logic                    wr_int_master;
   logic                    wr_flag;
   logic                    wr_counter;
   logic                    wr_control;
   logic                    wr_enable;
   logic                    wr_period;

   ////////////////////////////////////////////////////////////////////
   // Write channel
   assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
   assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr_i;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         w_held  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_held  <= 1'b1;
         w_byte  <= s_axi_wdata_i[7:0];
         w_lane0 <= s_axi_wstrb_i[0];
      end else if (do_write) begin
         w_held  <= 1'b0;
      end
   end

   assign do_write      = aw_held & w_held & ~s_axi_bvalid_o;
   assign wsel          = decode(aw_addr);
   assign wr_go         = do_write & w_lane0;
   assign wr_int_master = wr_go & (wsel == SEL_INT_MASTER);
   assign wr_flag       = wr_go & (wsel == SEL_FLAG);
   assign wr_counter    = wr_go & (wsel == SEL_COUNTER);
   assign wr_control    = wr_go & (wsel == SEL_CONTROL);
   assign wr_enable     = wr_go & (wsel == SEL_ENABLE);
   assign wr_period     = wr_go & (wsel == SEL_PERIOD);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read channel
   reg_sel_t   rsel;
   logic [7:0] read_byte;

   assign s_axi_arready_o = ~s_axi_rvalid_o;
   assign rsel            = decode(s_axi_araddr_i);

   always_comb begin
      case (rsel)
         SEL_INT_MASTER: read_byte = int_master;
         SEL_FLAG:       read_byte = {6'h00, match_flag, 1'b0};
         SEL_COUNTER:    read_byte = period_counter;
         SEL_CONTROL:    read_byte = {1'b0, timer_scaling_control};
         SEL_ENABLE:     read_byte = enable_reg;
         SEL_PERIOD:     read_byte = period_compare_value;
         default:        read_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= {24'h00_0000, read_byte};
         s_axi_rresp_o  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Plain control registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_master <= RST_INT_MASTER;
         enable_reg <= RST_ENABLE;
      end else begin
         if (wr_int_master) begin
            int_master <= w_byte;
         end
         if (wr_enable) begin
            enable_reg <= w_byte;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         period_compare_value <= RST_PERIOD;
      end else if (wr_period) begin
         period_compare_value <= w_byte;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_scaling_control <= RST_CONTROL;
      end else if (wr_control) begin
         timer_scaling_control <= w_byte[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Clock division and scaling
   logic [1:0] core_div;
   logic       core_tick;
   logic       counter_run_enable;
   logic [1:0] prescale_select;
   logic [3:0] postscale_select;
   logic [3:0] pre_limit;
   logic       scaler_clear;
   logic       pre_tick;
   logic       post_tick;
   logic       period_hit;
   logic       match_event;

   assign counter_run_enable = timer_scaling_control[RUN_BIT];
   assign prescale_select    = timer_scaling_control[PRE_LO+1:PRE_LO];
   assign postscale_select   = timer_scaling_control[POST_LO+3:POST_LO];

   assign core_tick = (core_div == CORE_DIV_LAST);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_div <= 2'h0;
      end else begin
         core_div <= core_div + 2'h1;
      end
   end

   assign pre_limit = prescale_select[1] ? PRE_LIMIT_16 :
                      prescale_select[0] ? PRE_LIMIT_4 : PRE_LIMIT_1;

   assign scaler_clear = wr_counter | wr_control;

   scale_counter #(
      .WIDTH (4)
   ) u_prescale (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (scaler_clear),
      .step_i  (core_tick & counter_run_enable),
      .limit_i (pre_limit),
      .tick_o  (pre_tick)
   );

   assign period_hit  = (period_counter == period_compare_value);
   assign match_event = pre_tick & period_hit & ~wr_counter;

   scale_counter #(
      .WIDTH (4)
   ) u_postscale (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (scaler_clear),
      .step_i  (match_event),
      .limit_i (postscale_select),
      .tick_o  (post_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Counter
   // reset clear and software load
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         period_counter <= RST_COUNTER;
      end else if (wr_counter) begin
         period_counter <= w_byte;
      end else if (match_event) begin
         period_counter <= 8'h00;
      end else if (pre_tick) begin
         period_counter <= period_counter + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Match flag and interrupt
   // postscaler sets flag
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         match_flag <= 1'b0;
      end else if (post_tick) begin
         match_flag <= 1'b1;
      end else if (wr_flag && w_byte[MATCH_FLAG_BIT]) begin
         match_flag <= 1'b0;
      end
   end

   assign irq_o = match_flag & enable_reg[MATCH_FLAG_BIT] &
                  int_master[PERIPH_IE_BIT] & int_master[GLOBAL_IE_BIT];

   ////////////////////////////////////////////////////////////////////
   // Outputs to serial port and PWM unit
   // prescaled match pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         match_pulse_o <= 1'b0;
      end else begin
         match_pulse_o <= match_event;
      end
   end

   assign counter_value_o = period_counter;
   assign period_value_o  = period_compare_value;

endmodule : period_match_timer_8bit

// file: period_match_timer_8bit_checker.sv
// Concurrent checks on the timer's bus handshake and timer outputs.
// Sees only top-level ports; bound to every timer instance.
`timescale 1ns/1ns
module period_match_timer_8bit_checker (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       s_axi_awvalid_i,
   input wire logic       s_axi_awready_o,
   input wire logic       s_axi_wvalid_i,
   input wire logic       s_axi_wready_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic [7:0] counter_value_o,
   input wire logic [7:0] period_value_o,
   input wire logic       match_pulse_o,
   input wire logic       irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////
   property p_wrap; match_pulse_o |-> counter_value_o == 8'h00
      && $past(counter_value_o) == $past(period_value_o); endproperty
   property p_pulse; match_pulse_o |=> !match_pulse_o [*3]; endproperty
   property p_step; $changed(counter_value_o) && !$rose(s_axi_bvalid_o) |->
      counter_value_o == $past(counter_value_o) + 8'h01 || counter_value_o == 8'h00; endproperty
   property p_gap; $changed(counter_value_o) && !$rose(s_axi_bvalid_o) |=>
      ($stable(counter_value_o) || $rose(s_axi_bvalid_o)) [*3]; endproperty
   property p_period; !$rose(s_axi_bvalid_o) |-> $stable(period_value_o); endproperty
   property p_irq; $fell(irq_o) |-> $rose(s_axi_bvalid_o); endproperty
   property p_wans; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o; endproperty
   property p_bref; $rose(s_axi_bvalid_o) |->
      !$past(s_axi_awready_o) && !$past(s_axi_wready_o); endproperty
   ////////////////////////////////////////////////////////////////////
   a_wrap: assert property (p_wrap) else $error("bad wrap");
   a_pulse: assert property (p_pulse) else $error("long pulse");
   a_step: assert property (p_step) else $error("bad step");
   a_gap: assert property (p_gap) else $error("fast count");
   a_period: assert property (p_period) else $error("period moved");
   a_irq: assert property (p_irq) else $error("irq dropped");
   a_wans: assert property (p_wans) else $error("no bvalid");
   a_bref: assert property (p_bref) else $error("ready in resp");
   c_match: cover property (match_pulse_o);
   c_irq: cover property ($rose(irq_o));
   c_write: cover property ($rose(s_axi_bvalid_o));
endmodule : period_match_timer_8bit_checker

bind period_match_timer_8bit period_match_timer_8bit_checker chk (.clk_i(clk_i),
   .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .counter_value_o(counter_value_o),
   .period_value_o(period_value_o), .match_pulse_o(match_pulse_o), .irq_o(irq_o));

// file: scale_counter.sv
// Modulo counter used as prescaler and postscaler.
// Assumes clear and step come from logic on the same clock.
`timescale 1ns/1ns
module scale_counter #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clear_i,
   input  wire logic             step_i,
   input  wire logic [WIDTH-1:0] limit_i,
   output logic                  tick_o
);

   logic [WIDTH-1:0] count;
   logic             at_limit;

   assign at_limit = (count >= limit_i);
   assign tick_o   = step_i & ~clear_i & at_limit;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count <= '0;
      end else if (clear_i || tick_o) begin
         count <= '0;
      end else if (step_i) begin
         count <= count + 1'b1;
      end
   end

endmodule : scale_counter

// file: tb_period_match_timer_8bit.sv
// Self-checking bench for the 8-bit period match timer.
// Drives the AXI4-Lite port itself; the checker is bound separately.
`timescale 1ns/1ns
module tb_period_match_timer_8bit;
   import timer_pkg::*;
   logic              clk_i, rst_i, awv, wv, bre, arv, rre;
   logic              awr, wr_, bv, arr, rv, mp, irq;
   logic [ADDR_W-1:0] awa, ara;
   logic [31:0]       wd, rdat;
   logic [1:0]        bresp, rresp;
   logic [7:0]        cnt, per;
   int                fail_count, tests_run;
   period_match_timer_8bit DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rre), .counter_value_o(cnt), .period_value_o(per),
      .match_pulse_o(mp), .irq_o(irq));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic a, w, b;
      logic [1:0] r;
      int n;
      n = 0;
      @(posedge clk_i);
      awa <= {2'b00, i, 2'b00};
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(negedge clk_i);
         a = awv & awr;
         w = wv & wr_;
         b = bv;
         r = bresp;
         @(posedge clk_i);
         if (a) awv <= 1'b0;
         if (w) wv <= 1'b0;
         n++;
      end while (b !== 1'b1 && n < 100);
      bre <= 1'b0;
      chk({37'h0, b, r}, {37'h0, 1'b1, er});
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
      logic a, v;
      logic [33:0] g;
      int n;
      n = 0;
      @(posedge clk_i);
      ara <= {2'b00, i, 2'b00};
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(negedge clk_i);
         a = arv & arr;
         v = rv;
         g = {rresp, rdat};
         @(posedge clk_i);
         if (a) arv <= 1'b0;
         n++;
      end while (v !== 1'b1 && n < 100);
      rre <= 1'b0;
      chk({5'h0, v, g}, {5'h0, 1'b1, er, 24'h0, e});
   endtask : rd
   task automatic wp(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (mp !== 1'b1 && n < 3000);
      chk({39'h0, mp}, {39'h0, 1'b1});
   endtask : wp
   task automatic irq_is(input logic e);
      @(negedge clk_i);
      chk({39'h0, irq}, {39'h0, e});
   endtask : irq_is
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(IDX_INT_MASTER, 8'h00);
      rd(IDX_FLAG, 8'h00);
      rd(IDX_COUNTER, 8'h00);
      rd(IDX_CONTROL, 8'h00);
      rd(IDX_ENABLE, 8'h00);
      rd(IDX_PERIOD, 8'hff);
      rd(8'h40, 8'h00, RESP_SLVERR);
      wr(8'h40, 8'h55, RESP_SLVERR);
      wr(IDX_PERIOD, 8'h5a);
      rd(IDX_PERIOD, 8'h5a);
      chk(40'(per), 40'h5a);
      wr(IDX_COUNTER, 8'h33);
      wr(IDX_CONTROL, 8'hf8);
      rd(IDX_CONTROL, 8'h78);
      rd(IDX_COUNTER, 8'h33);
      repeat (40) @(posedge clk_i);
      chk(40'(cnt), 40'h33);
      $display("register test done");
   endtask : t_regs
   task automatic t_pre;
      int n;
      wr(IDX_PERIOD, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wr(IDX_CONTROL, 8'h04 | 8'(k));
         wp(n);
         chk(40'(cnt), 40'h00);
         wp(n);
         chk(40'(n), 40'(8 * (k == 0 ? 1 : k == 1 ? 4 : 16)));
      end
      $display("prescale test done");
   endtask : t_pre
   task automatic t_post;
      int ps[3] = '{0, 1, 15};
      int n, c;
      wr(IDX_PERIOD, 8'h00);
      wr(IDX_INT_MASTER, 8'hc0);
      wr(IDX_ENABLE, 8'h02);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_CONTROL, 8'h00);
         wr(IDX_FLAG, 8'h02);
         wr(IDX_COUNTER, 8'hfe);
         wr(IDX_CONTROL, 8'(ps[i] << 3) | 8'h04);
         n = 0;
         c = 0;
         while (irq !== 1'b1 && c < 500) begin
            @(negedge clk_i);
            n += int'(mp);
            c++;
         end
         chk(40'(n), 40'(ps[i] + 1));
      end
      wr(IDX_CONTROL, 8'h00);
      rd(IDX_FLAG, 8'h02);
      wr(IDX_INT_MASTER, 8'h40);
      irq_is(1'b0);
      wr(IDX_INT_MASTER, 8'hc0);
      irq_is(1'b1);
      wr(IDX_ENABLE, 8'h00);
      irq_is(1'b0);
      wr(IDX_ENABLE, 8'h02);
      wr(IDX_FLAG, 8'h02);
      irq_is(1'b0);
      rd(IDX_FLAG, 8'h00);
      $display("postscale test done");
   endtask : t_post
   task automatic meas(input logic [7:0] i);
      int n;
      logic [7:0] v;
      repeat (30) @(negedge clk_i);
      v = (i == IDX_COUNTER) ? 8'h10 : cnt;
      wr(i, (i == IDX_COUNTER) ? 8'h10 : 8'h06);
      @(negedge clk_i);
      chk(40'(cnt), 40'(v));
      n = 1;
      while (cnt === v && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      chk(40'(n >= 61 && n <= 64), 40'h1);
   endtask : meas
   task automatic t_clear;
      wr(IDX_PERIOD, 8'hff);
      wr(IDX_CONTROL, 8'h06);
      meas(IDX_COUNTER);
      meas(IDX_CONTROL);
      wr(IDX_COUNTER, 8'h44);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({23'h0, cnt, per, irq}, {23'h0, 8'h00, 8'hff, 1'b0});
      rst_i <= 1'b0;
      rd(IDX_CONTROL, 8'h00);
      $display("scaler clear test done");
   endtask : t_clear
   ////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
   initial begin
      {rst_i, awv, wv, bre, arv, rre, awa, ara, wd} = {1'b1, 61'h0};
      fail_count = 0;
      tests_run = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_pre();
      t_post();
      t_clear();
      finish_test();
   end
endmodule : tb_period_match_timer_8bit

// file: timer_pkg.sv
// Constants for the 8-bit period match timer.
// Assumes an AXI4-Lite register bus with one 32-bit word per register.
package timer_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_INT_MASTER  = 8'h0b;
   localparam logic [7:0] IDX_FLAG        = 8'h0c;
   localparam logic [7:0] IDX_COUNTER     = 8'h11;
   localparam logic [7:0] IDX_CONTROL     = 8'h12;
   localparam logic [7:0] IDX_ENABLE      = 8'h8c;
   localparam logic [7:0] IDX_PERIOD      = 8'h92;
   localparam int         ADDR_W          = 12;

   ////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_INT_MASTER  = 8'h00;
   localparam logic [7:0] RST_ENABLE      = 8'h00;
   localparam logic [7:0] RST_COUNTER     = 8'h00;
   localparam logic [6:0] RST_CONTROL     = 7'h00;
   localparam logic [7:0] RST_PERIOD      = 8'hff;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int         MATCH_FLAG_BIT  = 1;
   localparam int         PERIPH_IE_BIT   = 6;
   localparam int         GLOBAL_IE_BIT   = 7;
   localparam int         RUN_BIT         = 2;
   localparam int         PRE_LO          = 0;
   localparam int         POST_LO         = 3;

   ////////////////////////////////////////////////////////////////////
   // Prescale limits (ratio minus one) and core clock divider
   localparam logic [3:0] PRE_LIMIT_1     = 4'h0;
   localparam logic [3:0] PRE_LIMIT_4     = 4'h3;
   localparam logic [3:0] PRE_LIMIT_16    = 4'hf;
   localparam logic [1:0] CORE_DIV_LAST   = 2'h3;

   ////////////////////////////////////////////////////////////////////
   // Bus answers
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum {
      SEL_NONE,
      SEL_INT_MASTER,
      SEL_FLAG,
      SEL_COUNTER,
      SEL_CONTROL,
      SEL_ENABLE,
      SEL_PERIOD
   } reg_sel_t;

endpackage : timer_pkg
